// ==== logic/bmc_pkg.sv ====
// constants and types shared by the backlight mode control block
package bmc_pkg;

  // register offsets
  localparam logic [7:0] BMC_ADDR_MODE = 8'h01;
  localparam logic [7:0] BMC_ADDR_STAT = 8'h02;
  localparam logic [7:0] BMC_ADDR_IEN  = 8'h03;

  // mode control bit positions
  localparam int BMC_B_BACKLIGHT_ON  = 0;
  localparam int BMC_B_AUTO_FOLLOW   = 1;
  localparam int BMC_B_SYNC_SINK     = 2;
  localparam int BMC_B_GAIN_INHIBIT  = 3;
  localparam int BMC_B_REDUCED_LEVEL = 4;
  localparam int BMC_B_NOT_STANDBY   = 5;
  localparam int BMC_B_INT_CFG       = 6;
  localparam int BMC_B_SEVENTH_AMB   = 7;

  // values after reset
  localparam logic [7:0] BMC_MODE_RST = 8'h00;
  localparam logic [5:0] BMC_STAT_RST = 6'h00;
  localparam logic [5:0] BMC_IEN_RST  = 6'h00;

  // widths
  localparam int BMC_NUM_FLAGS = 6;
  localparam int BMC_NUM_SINKS = 7;
  localparam int BMC_NUM_CMP   = 4;

  // interrupt release gap
  localparam int BMC_CLK_MHZ    = 250;
  localparam int BMC_GAP_US     = 50;
  localparam int BMC_GAP_CYCLES = BMC_GAP_US * BMC_CLK_MHZ;

  // ambient zones, darkest first
  typedef enum logic [2:0] {
    BMC_ZONE_DARK    = 3'b000,
    BMC_ZONE_INDOOR  = 3'b001,
    BMC_ZONE_OFFICE  = 3'b010,
    BMC_ZONE_BRIGHT  = 3'b011,
    BMC_ZONE_OUTDOOR = 3'b100
  } bmc_zone_e;

endpackage

// ==== logic/bmc_zone_encode.sv ====
// encoder from ambient comparator outputs to a zone
`timescale 1ns/1ps
module bmc_zone_encode
  import bmc_pkg::*;
#(
  parameter int NUM_CMP = BMC_NUM_CMP
)(
  input  wire logic [NUM_CMP-1:0] i_cmp_level,
  input  wire logic [NUM_CMP-1:0] i_level_enable,
  output bmc_zone_e               o_zone
);

  ////////////////////////////////////////////////////////////////////////////
  // highest enabled tripped comparator wins
  function automatic bmc_zone_e zone_of(input logic [NUM_CMP-1:0] hits);
    bmc_zone_e z;
    z = BMC_ZONE_DARK;
    for (int k = 0; k < NUM_CMP; k++)
    begin
      if (hits[k])
      begin
        z = bmc_zone_e'(3'(k + 1));
      end
    end
    return z;
  endfunction

  always_comb
  begin
    o_zone = zone_of(i_cmp_level & i_level_enable);
  end

endmodule

// ==== logic/bmc_gap_timer.sv ====
// one-shot timer holding a busy level for a fixed number of cycles
`timescale 1ns/1ps
module bmc_gap_timer
#(
  parameter int CYCLES = 16
)(
  input  wire logic i_clock,
  input  wire logic i_srst,
  input  wire logic i_start,
  output logic      o_busy
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic          busy_d;

  ////////////////////////////////////////////////////////////////////////////
  // busy for CYCLES cycles after the start pulse; restart extends it
  always_comb
  begin
    count_d = count_q;
    busy_d  = o_busy;
    if (i_start)
    begin
      count_d = CW'(CYCLES - 1);
      busy_d  = 1'b1;
    end
    else if (count_q != '0)
    begin
      count_d = count_q - CW'(1);
    end
    else
    begin
      busy_d = 1'b0;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      count_q <= '0;
      o_busy  <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      o_busy  <= busy_d;
    end
  end

endmodule

// ==== logic/bmc_mode_control.sv ====
// mode control register with interrupt flags and control outputs
`timescale 1ns/1ps
module bmc_mode_control
  import bmc_pkg::*;
#(
  parameter int GAP_CYCLES = BMC_GAP_CYCLES,
  parameter int NUM_SINKS  = BMC_NUM_SINKS,
  parameter int NUM_CMP    = BMC_NUM_CMP
)(
  input  wire logic                 i_clock,
  input  wire logic                 i_srst,
  input  wire logic                 i_reg_wr,
  input  wire logic                 i_reg_rd,
  input  wire logic [7:0]           i_reg_addr,
  input  wire logic [7:0]           i_reg_wdata,
  output logic      [7:0]           o_reg_rdata,
  input  wire logic                 i_dim_timeout,
  input  wire logic [5:0]           i_int_event,
  input  wire logic [NUM_SINKS-1:0] i_indep_sink_cfg,
  input  wire logic [NUM_SINKS-1:0] i_individual_sink_on,
  input  wire logic [NUM_CMP-1:0]   i_level_enable,
  input  wire logic [NUM_CMP-1:0]   i_cmp_level,
  input  wire logic [1:0]           i_manual_level_field,
  input  wire logic                 i_all_leds_off,
  output logic                      o_standby,
  output logic                      o_backlight_drive,
  output logic                      o_dim_active,
  output logic      [2:0]           o_bl_level,
  output logic                      o_seventh_ambient,
  output logic      [2:0]           o_seventh_zone,
  output logic      [NUM_SINKS-1:0] o_sink_on,
  output logic                      o_gain_down_allow,
  output logic                      o_gain_up_allow,
  output logic                      o_irq_n
);

  logic [7:0]           mode_q;
  logic [7:0]           mode_d;
  logic [5:0]           flag_q;
  logic [5:0]           flag_d;
  logic [5:0]           ien_q;
  logic [5:0]           ien_d;
  logic [7:0]           rdata_d;
  logic                 standby_d;
  logic                 drive_d;
  logic                 dim_d;
  logic [2:0]           level_d;
  logic                 seventh_d;
  logic [2:0]           seventh_zone_d;
  logic [NUM_SINKS-1:0] sink_d;
  logic                 gdown_d;
  logic                 gup_d;
  logic                 irq_n_d;
  logic                 wr_mode;
  logic                 wr_stat;
  logic                 wr_ien;
  logic                 clear_try;
  logic                 pend_after;
  logic                 gap_start;
  logic                 gap_busy;
  logic                 auto_live;
  bmc_zone_e            zone;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic is_write(input logic       wr,
                                    input logic [7:0] addr,
                                    input logic [7:0] target);
    return wr && (addr == target);
  endfunction

  bmc_zone_encode #(
    .NUM_CMP (NUM_CMP)
  ) u_zone (
    .i_cmp_level    (i_cmp_level),
    .i_level_enable (i_level_enable),
    .o_zone         (zone)
  );

  bmc_gap_timer #(
    .CYCLES (GAP_CYCLES)
  ) u_gap (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_start (gap_start),
    .o_busy  (gap_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register file

  always_comb
  begin
    wr_mode = is_write(i_reg_wr, i_reg_addr, BMC_ADDR_MODE);
    wr_stat = is_write(i_reg_wr, i_reg_addr, BMC_ADDR_STAT);
    wr_ien  = is_write(i_reg_wr, i_reg_addr, BMC_ADDR_IEN);
    mode_d  = mode_q;
    if (wr_mode)
    begin
      mode_d = i_reg_wdata;
    end
    if (i_dim_timeout)
    begin
      mode_d[BMC_B_REDUCED_LEVEL] = 1'b1;
    end
    ien_d = wr_ien ? i_reg_wdata[5:0] : ien_q;
    flag_d = flag_q;
    if (wr_stat)
    begin
      flag_d = flag_q & ~i_reg_wdata[5:0];
    end
    flag_d = flag_d | i_int_event;
    rdata_d = o_reg_rdata;
    if (i_reg_rd)
    begin
      unique case (i_reg_addr)
        BMC_ADDR_MODE: rdata_d = mode_q;
        BMC_ADDR_STAT: rdata_d = {2'b00, flag_q};
        BMC_ADDR_IEN:  rdata_d = {2'b00, ien_q};
        default:       rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      mode_q      <= BMC_MODE_RST;
      flag_q      <= BMC_STAT_RST;
      ien_q       <= BMC_IEN_RST;
      o_reg_rdata <= 8'h00;
    end
    else
    begin
      mode_q      <= mode_d;
      flag_q      <= flag_d;
      ien_q       <= ien_d;
      o_reg_rdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt output

  always_comb
  begin
    clear_try  = wr_stat && (i_reg_wdata[5:0] != 6'h00);
    pend_after = |(flag_d & ien_d);
    gap_start  = clear_try && pend_after && mode_q[BMC_B_INT_CFG];
    irq_n_d    = ~(pend_after && !gap_start && !gap_busy);
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_irq_n <= 1'b1;
    end
    else
    begin
      o_irq_n <= irq_n_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control outputs

  always_comb
  begin
    standby_d = !mode_q[BMC_B_NOT_STANDBY];
    drive_d   = mode_q[BMC_B_BACKLIGHT_ON] && !standby_d;
    dim_d     = drive_d && mode_q[BMC_B_REDUCED_LEVEL];
    auto_live = mode_q[BMC_B_AUTO_FOLLOW] && (|i_level_enable);
    level_d   = auto_live ? zone : {1'b0, i_manual_level_field};
    seventh_d = mode_q[BMC_B_SEVENTH_AMB] && i_indep_sink_cfg[NUM_SINKS-1]
                && auto_live && !standby_d;
    seventh_zone_d = seventh_d ? zone : BMC_ZONE_DARK;
    if (standby_d)
    begin
      sink_d = '0;
    end
    else if (|i_individual_sink_on)
    begin
      sink_d = i_individual_sink_on & i_indep_sink_cfg;
    end
    else
    begin
      sink_d = {NUM_SINKS{mode_q[BMC_B_SYNC_SINK]}} & i_indep_sink_cfg;
    end
    gdown_d = !standby_d
              && (!mode_q[BMC_B_GAIN_INHIBIT] || i_all_leds_off);
    gup_d   = !standby_d;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_standby         <= 1'b1;
      o_backlight_drive <= 1'b0;
      o_dim_active      <= 1'b0;
      o_bl_level        <= 3'h0;
      o_seventh_ambient <= 1'b0;
      o_seventh_zone    <= 3'h0;
      o_sink_on         <= '0;
      o_gain_down_allow <= 1'b0;
      o_gain_up_allow   <= 1'b0;
    end
    else
    begin
      o_standby         <= standby_d;
      o_backlight_drive <= drive_d;
      o_dim_active      <= dim_d;
      o_bl_level        <= level_d;
      o_seventh_ambient <= seventh_d;
      o_seventh_zone    <= seventh_zone_d;
      o_sink_on         <= sink_d;
      o_gain_down_allow <= gdown_d;
      o_gain_up_allow   <= gup_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);

  sequence s_clear_pending_cfg1;
    wr_stat && (i_reg_wdata[5:0] != 6'h00) && mode_q[BMC_B_INT_CFG]
    && (|(((flag_q & ~i_reg_wdata[5:0]) | i_int_event) & ien_q))
    && !wr_ien;
  endsequence

  sequence s_clear_pending_cfg0;
    wr_stat && (i_reg_wdata[5:0] != 6'h00) && !mode_q[BMC_B_INT_CFG]
    && !gap_busy && !o_irq_n
    && (|(((flag_q & ~i_reg_wdata[5:0]) | i_int_event) & ien_q))
    && !wr_ien;
  endsequence

  a_irq_gap_release: assert property (
    s_clear_pending_cfg1 |=> o_irq_n ##1 o_irq_n)
    else $error("interrupt not released after clear with pending event");

  a_irq_gap_end: assert property (
    $fell(gap_busy) && (|(flag_q & ien_q)) && !wr_stat && !wr_ien |=> !o_irq_n)
    else $error("interrupt not reasserted after release gap");

  a_irq_steady_hold: assert property (
    s_clear_pending_cfg0 |=> !o_irq_n ##1 !o_irq_n)
    else $error("interrupt dropped although event still pending");

  a_flag_write_clear: assert property (
    wr_stat && (i_int_event == 6'h00)
    |=> flag_q == ($past(flag_q) & ~$past(i_reg_wdata[5:0])))
    else $error("status flag not cleared by writing one");

  a_flag_read_keep: assert property (
    !wr_stat && (i_int_event == 6'h00) |=> flag_q == $past(flag_q))
    else $error("status flag changed without clear write");

  a_dim_hw_set: assert property (
    i_dim_timeout |=> mode_q[BMC_B_REDUCED_LEVEL] ##1 (o_reg_rdata[4] || !$past(i_reg_rd)
    || ($past(i_reg_addr) != BMC_ADDR_MODE)))
    else $error("reduced level bit not set by dim timeout");

  a_mode_readback: assert property (
    i_reg_rd && (i_reg_addr == BMC_ADDR_MODE) |=> o_reg_rdata == $past(mode_q))
    else $error("mode register read back wrong");

  a_drive_gate: assert property (
    o_backlight_drive |-> $past(mode_q[BMC_B_BACKLIGHT_ON])
    && $past(mode_q[BMC_B_NOT_STANDBY]) && !o_standby)
    else $error("backlight driven while off or in standby");

  a_dim_gate: assert property (
    o_dim_active |-> o_backlight_drive && $past(mode_q[BMC_B_REDUCED_LEVEL]))
    else $error("dim mode without backlight enabled");

  a_level_select: assert property (
    1'b1 |=> o_bl_level == ($past(mode_q[BMC_B_AUTO_FOLLOW]) && (|$past(i_level_enable))
      ? $past(zone) : {1'b0, $past(i_manual_level_field)}))
    else $error("backlight level source wrong");

  a_seventh_ambient: assert property (
    o_seventh_ambient |-> $past(mode_q[BMC_B_SEVENTH_AMB])
    && $past(mode_q[BMC_B_AUTO_FOLLOW]) && (|$past(i_level_enable))
    && $past(i_indep_sink_cfg[NUM_SINKS-1]) && (o_seventh_zone == o_bl_level))
    else $error("seventh sink ambient control out of conditions");

  a_sync_sinks: assert property (
    $past(mode_q[BMC_B_NOT_STANDBY]) && ($past(i_individual_sink_on) == '0)
    |-> o_sink_on == ({NUM_SINKS{$past(mode_q[BMC_B_SYNC_SINK])}} & $past(i_indep_sink_cfg)))
    else $error("independent sinks not switched together");

  a_gain_down: assert property (
    $past(mode_q[BMC_B_NOT_STANDBY]) |-> o_gain_down_allow ==
      (!$past(mode_q[BMC_B_GAIN_INHIBIT]) || $past(i_all_leds_off)))
    else $error("pump gain-down permission wrong");

  a_standby_follow: assert property (
    1'b1 |-> o_standby == !$past(mode_q[BMC_B_NOT_STANDBY]))
    else $error("standby output does not follow mode bit");

  a_gain_up_free: assert property (
    1'b1 |-> o_gain_up_allow == $past(mode_q[BMC_B_NOT_STANDBY]))
    else $error("pump gain-up permission wrong");

  a_standby_sinks: assert property (
    !$past(mode_q[BMC_B_NOT_STANDBY]) |-> o_sink_on == '0)
    else $error("sinks on during standby");

  a_indiv_override: assert property (
    $past(mode_q[BMC_B_NOT_STANDBY]) && ($past(i_individual_sink_on) != '0)
    |-> o_sink_on == ($past(i_individual_sink_on) & $past(i_indep_sink_cfg)))
    else $error("individual sink enables not taking precedence");

  a_seventh_zone_off: assert property (
    !o_seventh_ambient |-> o_seventh_zone == BMC_ZONE_DARK)
    else $error("seventh zone shown without ambient control");

endmodule

// ==== verif/bmc_host_model.sv ====
// host side model driving the register access strobes
`timescale 1ns/1ps
module bmc_host_model (
  input  wire logic       i_clock,
  input  wire logic [7:0] i_reg_rdata,
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  output logic [7:0]      o_reg_addr,
  output logic [7:0]      o_reg_wdata
);
  // idle cycles before each access, zero for a prompt host
  int gap = 0;

  initial
  begin
    o_reg_wr    = 1'h0;
    o_reg_rd    = 1'h0;
    o_reg_addr  = 8'h00;
    o_reg_wdata = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one write, returns at the edge that takes it; a status write of ones clears
  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    repeat (gap) @(posedge i_clock);
    @(posedge i_clock);
    o_reg_wr    <= 1'h1;
    o_reg_addr  <= addr;
    o_reg_wdata <= data;
    @(posedge i_clock);
    o_reg_wr    <= 1'h0;
    o_reg_addr  <= ~addr;
    o_reg_wdata <= ~data;
  endtask

  // one read, data taken once the registered answer has settled
  task automatic read(input logic [7:0] addr, output logic [7:0] data);
    repeat (gap) @(posedge i_clock);
    @(posedge i_clock);
    o_reg_rd   <= 1'h1;
    o_reg_addr <= addr;
    @(posedge i_clock);
    o_reg_rd   <= 1'h0;
    o_reg_addr <= ~addr;
    @(posedge i_clock);
    #1;
    data = i_reg_rdata;
  endtask
endmodule

// ==== verif/tb_top.sv ====
// testbench for the backlight mode control register block
`timescale 1ns/1ps
module tb_top;
  import bmc_pkg::*;
  localparam int GAP = 16;

  logic       clk;
  logic       srst;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       dim_timeout;
  logic [5:0] int_event;
  logic [6:0] indep_cfg;
  logic [6:0] indiv_on;
  logic [3:0] level_en;
  logic [3:0] cmp_level;
  logic [1:0] manual_level;
  logic       all_off;
  logic       standby;
  logic       bl_drive;
  logic       dim_active;
  logic [2:0] bl_level;
  logic       sev_amb;
  logic [2:0] sev_zone;
  logic [6:0] sink_on;
  logic       gain_down;
  logic       gain_up;
  logic       irq_n;
  logic [7:0] rd;
  int         n_mismatch = 0;
  int         num_checks = 0;

  bmc_host_model u_bmc_host_model (
    .i_clock(clk), .i_reg_rdata(reg_rdata), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
    .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata));

  bmc_mode_control #(.GAP_CYCLES(GAP)) u_bmc_mode_control (
    .i_clock(clk), .i_srst(srst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .i_dim_timeout(dim_timeout), .i_int_event(int_event), .i_indep_sink_cfg(indep_cfg),
    .i_individual_sink_on(indiv_on), .i_level_enable(level_en), .i_cmp_level(cmp_level),
    .i_manual_level_field(manual_level), .i_all_leds_off(all_off), .o_standby(standby),
    .o_backlight_drive(bl_drive), .o_dim_active(dim_active), .o_bl_level(bl_level),
    .o_seventh_ambient(sev_amb), .o_seventh_zone(sev_zone), .o_sink_on(sink_on),
    .o_gain_down_allow(gain_down), .o_gain_up_allow(gain_up), .o_irq_n(irq_n));

  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic set_mode(input logic [7:0] v);
    u_bmc_host_model.write(BMC_ADDR_MODE, v);
    settle(3);
  endtask

  task automatic fire_event(input logic [5:0] v);
    @(posedge clk);
    int_event <= v;
    @(posedge clk);
    int_event <= 6'h00;
    settle(3);
  endtask

  initial
  begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    srst = 1'h1;
    dim_timeout = 1'h0;
    int_event = 6'h00;
    indep_cfg = 7'h55;
    indiv_on = 7'h00;
    level_en = 4'hF;
    cmp_level = 4'h3;
    manual_level = 2'h3;
    all_off = 1'h0;
    repeat (16) @(posedge clk);
    srst <= 1'h0;
    settle(2);
    u_bmc_host_model.read(BMC_ADDR_MODE, rd);
    check("mode reset", rd, BMC_MODE_RST);
    check("standby reset", 8'(standby), 8'h01);
    u_bmc_host_model.read(8'h7F, rd);
    check("unmapped read", rd, 8'h00);
    $display("test reset done");

    set_mode(8'h21);
    check("standby", 8'(standby), 8'h00);
    check("drive on", 8'(bl_drive), 8'h01);
    set_mode(8'h01);
    check("drive standby", 8'(bl_drive), 8'h00);
    check("gain up standby", 8'(gain_up), 8'h00);
    set_mode(8'h20);
    check("drive off", 8'(bl_drive), 8'h00);
    $display("test standby done");

    @(posedge clk);
    dim_timeout <= 1'h1;
    @(posedge clk);
    dim_timeout <= 1'h0;
    settle(3);
    u_bmc_host_model.read(BMC_ADDR_MODE, rd);
    check("dim set by timer", rd, 8'h30);
    check("dim without bl", 8'(dim_active), 8'h00);
    set_mode(8'h21);
    check("dim cleared", 8'(dim_active), 8'h00);
    set_mode(8'h31);
    check("dim forced", 8'(dim_active), 8'h01);
    $display("test dim done");

    set_mode(8'h21);
    check("manual level", 8'(bl_level), 8'h03);
    set_mode(8'h23);
    check("auto level", 8'(bl_level), 8'h02);
    cmp_level <= 4'hF;
    set_mode(8'hA3);
    check("sev ambient", 8'(sev_amb), 8'h01);
    check("sev zone", 8'(sev_zone), 8'h04);
    level_en <= 4'h0;
    settle(3);
    check("sev no levels", 8'(sev_amb), 8'h00);
    check("auto no levels", 8'(bl_level), 8'h03);
    level_en <= 4'hF;
    set_mode(8'hA1);
    check("sev no auto", 8'(sev_amb), 8'h00);
    set_mode(8'h23);
    check("sev off", 8'(sev_amb), 8'h00);
    check("sev zone off", 8'(sev_zone), 8'h00);
    indep_cfg <= 7'h15;
    set_mode(8'hA3);
    check("sev not independent", 8'(sev_amb), 8'h00);
    $display("test ambient done");

    indep_cfg <= 7'h55;
    indiv_on <= 7'h00;
    set_mode(8'h24);
    check("sync on", 8'(sink_on), 8'h55);
    set_mode(8'h20);
    check("sync off", 8'(sink_on), 8'h00);
    indiv_on <= 7'h04;
    set_mode(8'h24);
    check("indiv over sync on", 8'(sink_on), 8'h04);
    set_mode(8'h20);
    check("indiv over sync off", 8'(sink_on), 8'h04);
    indiv_on <= 7'h00;
    $display("test sinks done");

    set_mode(8'h28);
    check("gain down held", 8'(gain_down), 8'h00);
    check("gain up free", 8'(gain_up), 8'h01);
    all_off <= 1'h1;
    settle(3);
    check("gain down leds off", 8'(gain_down), 8'h01);
    all_off <= 1'h0;
    set_mode(8'h20);
    check("gain down auto", 8'(gain_down), 8'h01);
    $display("test pump done");

    u_bmc_host_model.gap = 2;
    u_bmc_host_model.write(BMC_ADDR_IEN, 8'h03);
    set_mode(8'h60);
    fire_event(6'h03);
    check("irq asserted", 8'(irq_n), 8'h00);
    u_bmc_host_model.write(BMC_ADDR_STAT, 8'h01);
    #1;
    check("irq release start", 8'(irq_n), 8'h01);
    for (int k = 0; k < GAP; k++)
    begin
      settle(1);
      check("irq release gap", 8'(irq_n), 8'h01);
    end
    settle(2);
    check("irq reasserted", 8'(irq_n), 8'h00);
    u_bmc_host_model.read(BMC_ADDR_STAT, rd);
    check("flag after clear", rd, 8'h02);
    u_bmc_host_model.write(BMC_ADDR_STAT, 8'h00);
    u_bmc_host_model.read(BMC_ADDR_STAT, rd);
    check("flag after zero", rd, 8'h02);
    set_mode(8'h20);
    fire_event(6'h01);
    u_bmc_host_model.write(BMC_ADDR_STAT, 8'h01);
    for (int k = 0; k < 6; k++)
    begin
      settle(1);
      check("irq held", 8'(irq_n), 8'h00);
    end
    u_bmc_host_model.write(BMC_ADDR_STAT, 8'h02);
    settle(3);
    check("irq idle", 8'(irq_n), 8'h01);
    u_bmc_host_model.read(BMC_ADDR_IEN, rd);
    check("enable readback", rd, 8'h03);
    $display("test interrupt done");
    final_report();
  end
endmodule
